// *** hdl/uarx_fifo.sv ***
`timescale 1ns/1ps
// Two-deep receive buffer; each entry holds data, framing error and ninth bit.
module uarx_fifo (
  input wire logic clk_in,
  input wire logic rst_in,
  uarx_fifo_if.store fifo
);
  import uarx_pkg::*;

  logic [ENTRY_W-1:0] mem_q [FIFO_DEPTH]; // Entry storage.
  logic wr_ptr_q;                         // Next slot to fill.
  logic rd_ptr_q;                         // Oldest slot.
  logic [1:0] count_q;                    // Entries held, 0 to 2.
  logic do_push;
  logic do_pop;

  // Refuse a push when full and a pop when empty, so the count stays honest.
  assign do_push = fifo.push && (count_q != 2'h2);
  assign do_pop = fifo.pop && (count_q != 2'h0);

  // Each slot loads only when it is the write target.
  for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_slot
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        mem_q[i] <= '0;
      end else if (do_push && (wr_ptr_q == 1'(i))) begin
        mem_q[i] <= fifo.push_entry;
      end
    end
  end

  // Pointers advance in arrival order.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (do_pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  // Count follows push and pop together; both at once keep it unchanged.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= 2'h0;
    end else if (do_push && !do_pop) begin
      count_q <= count_q + 2'h1;
    end else if (do_pop && !do_push) begin
      count_q <= count_q - 2'h1;
    end
  end

  assign fifo.head = mem_q[rd_ptr_q];
  assign fifo.full = (count_q == 2'h2);
  assign fifo.empty = (count_q == 2'h0);

  a_fifo_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    count_q <= 2'h2) else $error("buffer count above two");
  // A second entry must queue behind the first, never overwrite the head.
  a_fifo_order: assert property (@(posedge clk_in) disable iff (rst_in)
    (do_push && count_q == 2'h1 && !do_pop) |=> (fifo.head == $past(fifo.head)))
    else $error("head changed on push");
  a_fifo_first: assert property (@(posedge clk_in) disable iff (rst_in)
    (do_push && count_q == 2'h0) |=> (fifo.head == $past(fifo.push_entry)))
    else $error("first entry not at head");

endmodule // uarx_fifo

// *** hdl/uarx_fifo_if.sv ***
`timescale 1ns/1ps
// Link between the receive engine and its two-entry buffer.
interface uarx_fifo_if;
  import uarx_pkg::*;
  logic push;                    // Store one entry.
  logic [ENTRY_W-1:0] push_entry; // Entry being stored.
  logic pop;                     // Drop the head entry.
  logic [ENTRY_W-1:0] head;      // Oldest entry.
  logic full;                    // Both entries taken.
  logic empty;                   // No entry held.
  modport store (input push, input push_entry, input pop, output head, output full,
                 output empty);
  modport user (output push, output push_entry, output pop, input head, input full,
                input empty);
endinterface

// *** hdl/uarx_pkg.sv ***
// Shared constants and types of the asynchronous serial receiver.
package uarx_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register byte addresses.
  localparam logic [7:0] ADDR_RSC = 8'h00;      // Receive status and control.
  localparam logic [7:0] ADDR_RXBUF = 8'h04;    // Receive buffer, read pops.
  localparam logic [7:0] ADDR_PFLAG = 8'h08;    // Peripheral flags.
  localparam logic [7:0] ADDR_PIE = 8'h0c;      // Peripheral interrupt enables.
  localparam logic [7:0] ADDR_EVT = 8'h10;      // Sticky events, clear on read.
  localparam logic [7:0] ADDR_EVT_MASK = 8'h14; // Event mask.
  localparam logic [7:0] ADDR_BAUD_LO = 8'h18;  // Oversample divisor, low byte.
  localparam logic [7:0] ADDR_BAUD_HI = 8'h1c;  // Oversample divisor, high byte.

  // Receive status and control fields.
  localparam int unsigned RSC_ASYNC_BIT = 7;
  localparam int unsigned RSC_NINE_BIT = 6;
  localparam int unsigned RSC_EN_BIT = 4;
  localparam int unsigned RSC_FRAMING_ERROR_BIT_BIT = 2;
  localparam int unsigned RSC_OVERRUN_ERROR_BIT_BIT = 1;
  localparam int unsigned RSC_NINTH_RECEIVED_BIT_BIT = 0;

  // Flag and enable positions of the receive interrupt.
  localparam int unsigned PFLAG_RCV_BIT = 5;
  localparam int unsigned PIE_RCV_BIT = 5;

  // Sticky event bits.
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_RX = 0;
  localparam int unsigned EVT_FRAMING_ERROR_BIT = 1;
  localparam int unsigned EVT_OVR = 2;

  // Oversampling and frame shape.
  localparam logic [3:0] PHASE_LAST = 4'hf;   // Sixteen ticks per bit.
  localparam logic [3:0] VOTE_PHASE = 4'h9;   // Majority of ticks 6, 7 and 8.
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [15:0] BAUD_RST = 16'h000f;

  // Buffer entry layout.
  localparam int unsigned FIFO_DEPTH = 2;
  localparam int unsigned ENTRY_W = 10;
  localparam int unsigned ENTRY_NINTH = 9;
  localparam int unsigned ENTRY_FRAMING_ERROR_BIT = 8;

  // Receiver states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_NINTH = 5'b01000,
    ST_STOP = 5'b10000
  } uarx_state_t;

endpackage

// *** hdl/uarx_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Sixteen-times oversampling feeds a per-bit shifter.
// - Frames accepted only with enable and async.
// - Stop bit moves shift word into buffer.
// - Receive flag set on transfer, clears when empty.
// - Receive interrupt only while its enable set.
// - Buffer holds two bytes, third still shifts.
// - Two reads return bytes in arrival order.
// - Stop with full buffer sets overrun, drops.
// - Overrun blocks every further buffer transfer.
// - Overrun clears by toggling receive enable off.
// - Stop bit sampled low sets framing error.
// - Framing and ninth bit stored per entry.
module uarx_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_receive_pin_in,
  input wire logic [uarx_pkg::ADDR_W-1:0] addr_in,
  input wire logic [uarx_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [uarx_pkg::DATA_W-1:0] rdata_out,
  output logic irq_out
);
  import uarx_pkg::*;

  uarx_fifo_if fifo (); // Buffer link.

  // Control registers.
  logic async_sel_q;       // Asynchronous mode selected.
  logic nine_en_q;         // Ninth bit expected in each frame.
  logic receive_enable_bit_q; // Receive enable.
  logic receive_irq_enable_q; // Receive interrupt enable.
  logic [15:0] baud_div_q; // Oversample tick every divisor plus one clocks.
  logic [EVT_W-1:0] evt_q; // Sticky events.
  logic [EVT_W-1:0] evt_mask_q; // Event mask.
  logic overrun_error_bit_q;    // Overrun latched.
  logic receive_flag_q;         // Buffer holds data.
  logic [DATA_W-1:0] rdata_q;   // Read answer.
  logic irq_q;                  // Interrupt output.

  // Receive engine state.
  uarx_state_t state_q;
  logic [15:0] baud_cnt_q;  // Divider count.
  logic tick_q;             // One-cycle sixteenth-bit pulse.
  logic line_q;             // Registered pin level.
  logic [2:0] samples_q;    // Data-recovery shifter.
  logic [3:0] phase_q;      // Tick within the current bit.
  logic [3:0] bitcnt_q;     // Data bits taken.
  logic [7:0] receive_shift_register_q; // Main per-bit shifter.
  logic ninth_received_bit_q; // Ninth bit of the current frame.

  logic rx_active;
  logic vote;
  logic at_vote;
  logic at_last;
  logic stop_done;
  logic push;
  logic ovr_set;
  logic buf_rd;
  logic evt_rd;
  logic [EVT_W-1:0] evt_set;
  logic irq_d;

  // The receiver runs only with both mode and enable bits set.
  assign rx_active = receive_enable_bit_q && async_sel_q;
  // Majority of three samples rejects a single-tick glitch near mid bit.
  assign vote = (samples_q[0] & samples_q[1]) | (samples_q[0] & samples_q[2]) |
                (samples_q[1] & samples_q[2]);
  assign at_vote = tick_q && (phase_q == VOTE_PHASE);
  assign at_last = tick_q && (phase_q == PHASE_LAST);
  assign stop_done = at_vote && (state_q == ST_STOP);
  // A transfer needs a free entry and no pending overrun.
  assign push = stop_done && !fifo.full && !overrun_error_bit_q;
  assign ovr_set = stop_done && fifo.full && !overrun_error_bit_q;
  assign buf_rd = rd_in && (addr_in == ADDR_RXBUF);
  assign evt_rd = rd_in && (addr_in == ADDR_EVT);

  // Entry layout keeps framing error and ninth bit beside the byte.
  assign fifo.push = push;
  assign fifo.push_entry = {ninth_received_bit_q && nine_en_q, !vote,
                            receive_shift_register_q};
  assign fifo.pop = buf_rd && !fifo.empty;

  uarx_fifo u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .fifo(fifo)
  );

  // Oversample divider; held cleared while the receiver is inactive so a fresh enable starts clean.
  always_ff @(posedge clk_in) begin
    if (rst_in || !rx_active) begin
      baud_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (baud_cnt_q >= baud_div_q) begin
      baud_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Pin is synchronous already; one register only aligns it with the ticks.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_q <= 1'b1;
      samples_q <= 3'h7;
    end else begin
      line_q <= serial_receive_pin_in;
      if (tick_q) begin
        samples_q <= {samples_q[1:0], line_q};
      end
    end
  end

  // Frame sequencer, advanced only by oversample ticks.
  always_ff @(posedge clk_in) begin
    if (rst_in || !rx_active) begin
      state_q <= ST_IDLE;
      phase_q <= 4'h0;
      bitcnt_q <= 4'h0;
    end else if (tick_q) begin
      case (state_q)
        ST_IDLE: begin
          // A low line begins the start bit.
          phase_q <= 4'h0;
          bitcnt_q <= 4'h0;
          if (!line_q) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          phase_q <= phase_q + 4'h1;
          if (at_vote && vote) begin
            // A high vote means the low level was noise.
            state_q <= ST_IDLE;
            phase_q <= 4'h0;
          end else if (at_last) begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          phase_q <= phase_q + 4'h1;
          if (at_vote) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          if (at_last && bitcnt_q == DATA_BITS) begin
            state_q <= nine_en_q ? ST_NINTH : ST_STOP;
          end
        end
        ST_NINTH: begin
          phase_q <= phase_q + 4'h1;
          if (at_last) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          // Leave at mid stop bit so a following start edge is not missed.
          phase_q <= phase_q + 4'h1;
          if (at_vote) begin
            state_q <= ST_IDLE;
            phase_q <= 4'h0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          phase_q <= 4'h0;
        end
      endcase
    end
  end

  // Main shifter takes one voted bit per bit time, least significant first.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      receive_shift_register_q <= 8'h00;
      ninth_received_bit_q <= 1'b0;
    end else if (at_vote && state_q == ST_DATA) begin
      receive_shift_register_q <= {vote, receive_shift_register_q[7:1]};
    end else if (at_vote && state_q == ST_NINTH) begin
      ninth_received_bit_q <= vote;
    end
  end

  // Overrun latches until enable drops; nothing else clears it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      overrun_error_bit_q <= 1'b0;
    end else if (ovr_set) begin
      overrun_error_bit_q <= 1'b1;
    end else if (!receive_enable_bit_q) begin
      overrun_error_bit_q <= 1'b0;
    end
  end

  // Receive flag follows buffer occupancy; a push always wins over a pop.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      receive_flag_q <= 1'b0;
    end else begin
      receive_flag_q <= push || !(fifo.empty || (fifo.pop && !fifo.full));
    end
  end

  // Software control registers; status bits are read-only.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      async_sel_q <= 1'b0;
      nine_en_q <= 1'b0;
      receive_enable_bit_q <= 1'b0;
      receive_irq_enable_q <= 1'b0;
      evt_mask_q <= '0;
      baud_div_q <= BAUD_RST;
    end else if (wr_in) begin
      case (addr_in)
        ADDR_RSC: begin
          async_sel_q <= wdata_in[RSC_ASYNC_BIT];
          nine_en_q <= wdata_in[RSC_NINE_BIT];
          receive_enable_bit_q <= wdata_in[RSC_EN_BIT];
        end
        ADDR_PIE: receive_irq_enable_q <= wdata_in[PIE_RCV_BIT];
        ADDR_EVT_MASK: evt_mask_q <= wdata_in[EVT_W-1:0];
        ADDR_BAUD_LO: baud_div_q[7:0] <= wdata_in;
        ADDR_BAUD_HI: baud_div_q[15:8] <= wdata_in;
        default: begin
          // Writes elsewhere are ignored.
        end
      endcase
    end
  end

  // Sticky events; a new event in the clearing read cycle survives.
  assign evt_set = {ovr_set, push && fifo.push_entry[ENTRY_FRAMING_ERROR_BIT], push};
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      evt_q <= '0;
    end else begin
      evt_q <= (evt_rd ? '0 : evt_q) | evt_set;
    end
  end

  // Read answer, one cycle after the strobe; head bits show the oldest entry.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else if (rd_in) begin
      rdata_q <= 8'h00;
      case (addr_in)
        ADDR_RSC: begin
          rdata_q[RSC_ASYNC_BIT] <= async_sel_q;
          rdata_q[RSC_NINE_BIT] <= nine_en_q;
          rdata_q[RSC_EN_BIT] <= receive_enable_bit_q;
          rdata_q[RSC_FRAMING_ERROR_BIT_BIT] <= !fifo.empty && fifo.head[ENTRY_FRAMING_ERROR_BIT];
          rdata_q[RSC_OVERRUN_ERROR_BIT_BIT] <= overrun_error_bit_q;
          rdata_q[RSC_NINTH_RECEIVED_BIT_BIT] <= !fifo.empty && fifo.head[ENTRY_NINTH];
        end
        ADDR_RXBUF: rdata_q <= fifo.empty ? 8'h00 : fifo.head[7:0];
        ADDR_PFLAG: rdata_q[PFLAG_RCV_BIT] <= receive_flag_q;
        ADDR_PIE: rdata_q[PIE_RCV_BIT] <= receive_irq_enable_q;
        ADDR_EVT: rdata_q[EVT_W-1:0] <= evt_q;
        ADDR_EVT_MASK: rdata_q[EVT_W-1:0] <= evt_mask_q;
        ADDR_BAUD_LO: rdata_q <= baud_div_q[7:0];
        ADDR_BAUD_HI: rdata_q <= baud_div_q[15:8];
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Interrupt level from the gated receive flag and masked events.
  assign irq_d = (receive_flag_q && receive_irq_enable_q) || (|(evt_q & evt_mask_q));
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out = irq_q;

  a_tick_gates_phase: assert property (@(posedge clk_in) disable iff (rst_in)
    (!tick_q && rx_active && $past(rx_active)) |=> $stable(phase_q))
    else $error("phase moved without a tick");
  a_push_needs_enable: assert property (@(posedge clk_in) disable iff (rst_in)
    push |-> (receive_enable_bit_q && async_sel_q))
    else $error("transfer while receiver disabled");
  a_stop_transfers: assert property (@(posedge clk_in) disable iff (rst_in)
    (stop_done && !fifo.full && !overrun_error_bit_q) |=> !fifo.empty)
    else $error("stop bit did not fill buffer");
  a_flag_after_push: assert property (@(posedge clk_in) disable iff (rst_in)
    push |=> receive_flag_q) else $error("receive flag not set");
  a_irq_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    (!receive_irq_enable_q && ((evt_q & evt_mask_q) == '0)) |=> !irq_q)
    else $error("interrupt without enabled cause");
  a_ovr_on_full: assert property (@(posedge clk_in) disable iff (rst_in)
    (stop_done && fifo.full && !fifo.pop) |=> overrun_error_bit_q ##0 $stable(fifo.head))
    else $error("overrun not flagged");
  a_ovr_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
    (overrun_error_bit_q && !fifo.pop) |=> ($stable(fifo.full) && $stable(fifo.empty)))
    else $error("transfer during overrun");
  a_ovr_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    (overrun_error_bit_q && receive_enable_bit_q) |=> overrun_error_bit_q)
    else $error("overrun cleared without toggle");
  a_framing_error_bit_low_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    (push && !vote) |=> evt_q[EVT_FRAMING_ERROR_BIT])
    else $error("framing error mismatch");

endmodule // uarx_top

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// Self-checking bench of the serial receiver, with a far-end transmitter model.
module testbench;
  import uarx_pkg::*;
  logic clk_in = 1'b0; // The 250 MHz clock.
  logic rst_in = 1'b1; // Synchronous reset.
  logic line; // Serial line from the far end.
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata_out;
  logic irq_out;
  logic go = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_ninth = 1'b0;
  logic tx_nine_en = 1'b0;
  logic tx_stop = 1'b1;
  logic tx_busy;
  logic [7:0] bit_clks = 8'h10; // Far-end bit time, in clocks.
  logic [31:0] seed = 32'had4c259a; // Fixed seed keeps runs repeatable.
  logic [7:0] b [0:7]; // Random bytes sent.
  int err_count = 0;
  int total_checks = 0;

  always #2 clk_in = ~clk_in;

  uarx_top i_uarx_top (.clk_in(clk_in), .rst_in(rst_in), .serial_receive_pin_in(line),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out),
    .irq_out(irq_out));

  uarx_tx_model i_uarx_tx_model (.clk_in(clk_in), .bit_clks_in(bit_clks), .go_in(go),
    .data_in(tx_data), .ninth_in(tx_ninth), .nine_en_in(tx_nine_en), .stop_in(tx_stop),
    .line_out(line), .busy_out(tx_busy));

  // Next state of the random source.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected status byte from the control bits and the head entry.
  function automatic logic [7:0] rsc_exp(input logic [7:0] ctrl, input logic framing_error_bit,
                                         input logic ovr, input logic r9);
    logic [7:0] v;
    v = ctrl;
    v[RSC_FRAMING_ERROR_BIT_BIT] = framing_error_bit;
    v[RSC_OVERRUN_ERROR_BIT_BIT] = ovr;
    v[RSC_NINTH_RECEIVED_BIT_BIT] = r9;
    return v;
  endfunction

  // Compares one value and counts the result.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string name);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    check(name, rdata_out, e);
  endtask

  // The interrupt is registered, so let it settle before looking.
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk_in);
    #1;
    check("irq", {7'h00, irq_out}, {7'h00, e});
  endtask

  // Sends one frame and waits, bounded, for the far end to finish.
  task automatic send(input logic [7:0] d, input logic n9, input logic st);
    @(posedge clk_in);
    tx_data <= d;
    tx_ninth <= n9;
    tx_stop <= st;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    for (int i = 0; i < 800; i++) begin
      @(posedge clk_in);
      #1;
      if (tx_busy === 1'b0) break;
    end
    // A far end that never finishes counts as a mismatch.
    if (tx_busy !== 1'b0) err_count++;
    repeat (2) @(posedge clk_in);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A hang is cut short well after the frames should have finished.
  initial begin
    repeat (30000) @(posedge clk_in);
    err_count++;
    results();
  end

  // Main sequence.
  initial begin
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      b[i] = seed[7:0];
    end
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(ADDR_RSC, 8'h00, "rsc reset");
    rd_chk(ADDR_PFLAG, 8'h00, "flag reset");
    rd_chk(ADDR_BAUD_LO, 8'h0f, "baud lo reset");
    rd_chk(ADDR_BAUD_HI, 8'h00, "baud hi reset");
    rd_chk(8'h20, 8'h00, "unmapped");
    wr_reg(ADDR_BAUD_LO, 8'h00);
    wr_reg(ADDR_PIE, 8'h20);
    wr_reg(ADDR_EVT_MASK, 8'h00);
    // Async alone, then enable alone: neither may accept a frame.
    wr_reg(ADDR_RSC, 8'h80);
    send(b[0], 1'b0, 1'b1);
    rd_chk(ADDR_PFLAG, 8'h00, "flag async only");
    wr_reg(ADDR_RSC, 8'h10);
    send(b[1], 1'b0, 1'b1);
    rd_chk(ADDR_PFLAG, 8'h00, "flag enable only");
    wr_reg(ADDR_RSC, 8'h90);
    for (int i = 0; i < 3; i++) begin
      send(b[i], 1'b0, 1'b1);
      irq_chk(1'b1);
      rd_chk(ADDR_PFLAG, 8'h20, "flag set");
      rd_chk(ADDR_RSC, rsc_exp(8'h90, 1'b0, 1'b0, 1'b0), "rsc clean");
      rd_chk(ADDR_RXBUF, b[i], "rx byte");
      rd_chk(ADDR_PFLAG, 8'h00, "flag clear");
      irq_chk(1'b0);
    end
    // With its enable off the flag raises no interrupt.
    wr_reg(ADDR_PIE, 8'h00);
    send(b[3], 1'b0, 1'b1);
    irq_chk(1'b0);
    wr_reg(ADDR_PIE, 8'h20);
    irq_chk(1'b1);
    rd_chk(ADDR_RXBUF, b[3], "masked byte");
    // Three frames into two entries: the third overruns; a fourth, with room free, is blocked.
    for (int i = 4; i < 7; i++) send(b[i], 1'b0, 1'b1);
    rd_chk(ADDR_RSC, rsc_exp(8'h90, 1'b0, 1'b1, 1'b0), "rsc overrun");
    rd_chk(ADDR_RXBUF, b[4], "fifo first");
    send(b[7], 1'b0, 1'b1);
    rd_chk(ADDR_RXBUF, b[5], "fifo second");
    rd_chk(ADDR_RXBUF, 8'h00, "fifo dropped");
    rd_chk(ADDR_PFLAG, 8'h00, "flag empty");
    wr_reg(ADDR_RSC, 8'h80);
    wr_reg(ADDR_RSC, 8'h90);
    rd_chk(ADDR_RSC, rsc_exp(8'h90, 1'b0, 1'b0, 1'b0), "overrun cleared");
    send(b[0], 1'b0, 1'b1);
    rd_chk(ADDR_RXBUF, b[0], "resumed byte");
    // A divisor of one halves the tick rate, so a bit lasts thirty-two clocks.
    wr_reg(ADDR_BAUD_LO, 8'h01);
    bit_clks <= 8'h20;
    send(b[5], 1'b0, 1'b1);
    rd_chk(ADDR_RXBUF, b[5], "slow byte");
    wr_reg(ADDR_BAUD_LO, 8'h00);
    bit_clks <= 8'h10;
    // Ninth bit and framing error travel with each entry.
    rd_chk(ADDR_EVT, 8'h05, "events so far");
    wr_reg(ADDR_PIE, 8'h00);
    wr_reg(ADDR_EVT_MASK, 8'h02);
    wr_reg(ADDR_RSC, 8'hd0);
    tx_nine_en <= 1'b1;
    send(b[1], 1'b1, 1'b0);
    send(b[2], 1'b0, 1'b1);
    irq_chk(1'b1);
    rd_chk(ADDR_RSC, rsc_exp(8'hd0, 1'b1, 1'b0, 1'b1), "rsc head one");
    rd_chk(ADDR_RXBUF, b[1], "framing_error_bit byte");
    rd_chk(ADDR_RSC, rsc_exp(8'hd0, 1'b0, 1'b0, 1'b0), "rsc head two");
    rd_chk(ADDR_RXBUF, b[2], "ninth byte");
    rd_chk(ADDR_EVT, 8'h03, "events frame");
    rd_chk(ADDR_EVT, 8'h00, "events cleared");
    irq_chk(1'b0);
    results();
  end
endmodule // testbench

// *** tb/uarx_tx_model.sv ***
`timescale 1ns/1ps
// Far-end transmitter: one frame for each go pulse, then one idle bit time.
module uarx_tx_model (
  input wire logic clk_in,
  input wire logic [7:0] bit_clks_in, // Clocks per bit; sixteen times divisor plus one.
  input wire logic go_in,
  input wire logic [7:0] data_in,
  input wire logic ninth_in,
  input wire logic nine_en_in,
  input wire logic stop_in,
  output logic line_out,
  output logic busy_out
);
  logic [7:0] data_q; // Byte latched when the frame starts.

  // The line idles high, as its pull-up would leave it.
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
  end

  // Holds one level for a whole bit time and changes only just after an edge.
  task automatic send_bit(input logic b);
    line_out <= b;
    repeat (bit_clks_in) @(posedge clk_in);
  endtask

  // A frame is a low start, eight bits LSB first, an optional ninth bit and the stop level.
  always begin
    @(posedge clk_in);
    if (go_in === 1'b1) begin
      busy_out <= 1'b1;
      data_q = data_in;
      send_bit(1'b0);
      for (int i = 0; i < 8; i++) begin
        send_bit(data_q[i]);
      end
      if (nine_en_in) begin
        send_bit(ninth_in);
      end
      send_bit(stop_in);
      // An idle bit keeps a low stop level from being taken for the next start.
      send_bit(1'b1);
      busy_out <= 1'b0;
    end
  end
endmodule // uarx_tx_model
